// ### rtl/pcn_pkg.sv
// Shared constants, bus carriers and state layout for the pin function block
package pcn_pkg;
  localparam int CN_N = 84;
  localparam int RP_N = 44;
  localparam int RP_IO = 32;
  localparam int PIN_IN_N = 4;
  localparam int FN_N = 25;
  localparam int WD = 32;
  localparam int BANK_W = 96;
  localparam int MAP_W = 6;
  localparam int PORT_G_ANALOG_SELECT_W = 4;
  localparam int PORT_G_ANALOG_SELECT_LO = 6;
  localparam int PORT_F_ANALOG_SELECT_BIT = 0;
  localparam int LOCK_BIT = 0;
  localparam int KEY_LO = 8;
  localparam int FLD_STEP = 8;
  localparam int FLD_PER_W = 4;
  localparam int RP_B = CN_N;
  localparam int F_B = CN_N + RP_N;
  localparam int G_B = F_B + 1;
  localparam int PAD_N = G_B + PORT_G_ANALOG_SELECT_W;
  localparam logic [3:0] BLK_ANS = 4'h0;
  localparam logic [3:0] BLK_CNEN = 4'h1;
  localparam logic [3:0] BLK_CNPU = 4'h2;
  localparam logic [3:0] BLK_CNPD = 4'h3;
  localparam logic [3:0] BLK_FLAG = 4'h4;
  localparam logic [3:0] BLK_CTL = 4'h5;
  localparam logic [3:0] BLK_OMAP0 = 4'h6;
  localparam logic [3:0] BLK_OMAP1 = 4'h7;
  localparam logic [1:0] W_PORT_F_ANALOG_SELECT = 2'h0;
  localparam logic [1:0] W_PORT_G_ANALOG_SELECT = 2'h1;
  localparam logic [1:0] W_LOCK = 2'h0;
  localparam logic [1:0] W_IMAP = 2'h1;
  localparam logic [1:0] W_NONE = 2'h3;
  localparam logic [7:0] PORT_F_ANALOG_SELECT_OFF = 8'h00;
  localparam logic [7:0] LOCK_KEY = 8'ha5;
  localparam logic PORT_F_ANALOG_SELECT_RST = 1'b1;
  localparam logic [3:0] PORT_G_ANALOG_SELECT_RST = 4'hf;
  localparam logic [5:0] MAP_NULL = 6'h00;
  localparam logic [5:0] NONE_PIN = 6'h3f;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } pcn_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } pcn_apb_rsp_s;

  typedef struct packed {
    logic port_f_analog_select;
    logic [3:0] port_g_analog_select;
    logic [95:0] cnen;
    logic [95:0] cnpu;
    logic [95:0] cnpd;
    logic [83:0] flag;
    logic [83:0] last;
    logic lock;
    logic [3:0][5:0] inmap;
    logic [31:0][5:0] outmap;
    logic [132:0] s1;
    logic [132:0] s2;
    logic [132:0] s3;
    logic [132:0] filt;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic [31:0] rp_out;
    logic [31:0] rp_oe_n;
    logic [3:0] pin_in;
    logic f_rd;
    logic [3:0] g_rd;
  } pcn_state_s;
endpackage

// ### rtl/pcn_pin_func.sv
// Analog select, change notification and remappable pin routing with APB registers
//
// Chosen here: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none

module pcn_pin_func (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire pcn_pkg::pcn_apb_req_s apb_req,
  output pcn_pkg::pcn_apb_rsp_s apb_rsp,
  input wire logic [83:0] cn_pin,
  input wire logic [43:0] rp_pin,
  input wire logic portf_pad,
  input wire logic [3:0] portg_pad,
  input wire logic [43:0] rp_analog,
  input wire logic [31:0] tris,
  input wire logic [31:0] gpio_out,
  input wire logic [31:0] pmp_en,
  input wire logic [31:0] pmp_out,
  input wire logic [31:0] usb_en,
  input wire logic [31:0] usb_out,
  input wire logic [25:1] periph_out,
  output logic [3:0] periph_in,
  output logic [31:0] rp_out,
  output logic [31:0] rp_oe_n,
  output logic cn_irq,
  output logic [83:0] pullup_en,
  output logic [83:0] pulldown_en,
  output logic portf_pin0_analog_sel,
  output logic [3:0] portg_pins_analog_sel,
  output logic portf_read,
  output logic [3:0] portg_read
);
  pcn_pkg::pcn_state_s r_reg;
  pcn_pkg::pcn_state_s r_next;

  logic [132:0] pads;
  logic [132:0] agree;
  logic [83:0] chg;
  logic [95:0] clr;
  logic [95:0] bank;
  logic [95:0] cn_mask;
  logic [31:0] rd;
  logic [3:0] blk;
  logic [1:0] wi;
  logic setup;
  logic acc;
  logic hit;
  logic [5:0] code;
  logic [5:0] sel;
  logic pv;
  int ow;

  assign pads = {portg_pad, portf_pad, rp_pin, cn_pin};
  assign cn_mask = {{(pcn_pkg::BANK_W - pcn_pkg::CN_N){1'b0}}, {pcn_pkg::CN_N{1'b1}}};
  assign blk = apb_req.paddr[7:4];
  assign wi = apb_req.paddr[3:2];
  assign setup = apb_req.psel & ~apb_req.penable;
  assign acc = apb_req.psel & apb_req.penable & r_reg.pready;

  always_comb begin
    r_next = r_reg;
    rd = '0;
    hit = 1'b1;
    bank = '0;
    clr = '0;
    code = pcn_pkg::MAP_NULL;
    sel = pcn_pkg::NONE_PIN;
    pv = 1'b0;
    ow = 0;
    // Three stages; a level counts once the last two agree
    r_next.s1 = pads;
    r_next.s2 = r_reg.s1;
    r_next.s3 = r_reg.s2;
    agree = ~(r_reg.s2 ^ r_reg.s3);
    r_next.filt = (r_reg.filt & ~agree) | (r_reg.s3 & agree);
    // last level is held across stopped clocks, so a sleep change shows on wake
    chg = (r_reg.filt[pcn_pkg::CN_N-1:0] ^ r_reg.last) & r_reg.cnen[pcn_pkg::CN_N-1:0];
    r_next.last = r_reg.filt[pcn_pkg::CN_N-1:0];

    // Bank word selection for the read path; writes index the registers directly
    unique case (blk)
      pcn_pkg::BLK_CNEN: bank = r_reg.cnen;
      pcn_pkg::BLK_CNPU: bank = r_reg.cnpu;
      pcn_pkg::BLK_CNPD: bank = r_reg.cnpd;
      pcn_pkg::BLK_FLAG: bank = {{(pcn_pkg::BANK_W - pcn_pkg::CN_N){1'b0}}, r_reg.flag};
      default: bank = '0;
    endcase

    // Read data is captured in the setup phase; the access phase always completes
    if (blk == pcn_pkg::BLK_ANS) begin
      // unimplemented positions stay zero in the read word
      if (wi == pcn_pkg::W_PORT_F_ANALOG_SELECT) begin
        rd[pcn_pkg::PORT_F_ANALOG_SELECT_BIT] = r_reg.port_f_analog_select;
      end else if (wi == pcn_pkg::W_PORT_G_ANALOG_SELECT) begin
        rd[pcn_pkg::PORT_G_ANALOG_SELECT_LO +: pcn_pkg::PORT_G_ANALOG_SELECT_W] = r_reg.port_g_analog_select;
      end else begin
        hit = 1'b0;
      end
    end else if (blk == pcn_pkg::BLK_CNEN || blk == pcn_pkg::BLK_CNPU ||
                 blk == pcn_pkg::BLK_CNPD || blk == pcn_pkg::BLK_FLAG) begin
      if (wi != pcn_pkg::W_NONE) begin
        rd = bank[wi * pcn_pkg::WD +: pcn_pkg::WD];
      end else begin
        hit = 1'b0;
      end
    end else if (blk == pcn_pkg::BLK_CTL) begin
      if (wi == pcn_pkg::W_LOCK) begin
        rd[pcn_pkg::LOCK_BIT] = r_reg.lock;
      end else if (wi == pcn_pkg::W_IMAP) begin
        for (int j = 0; j < pcn_pkg::PIN_IN_N; j++) begin
          rd[j * pcn_pkg::FLD_STEP +: pcn_pkg::MAP_W] = r_reg.inmap[j];
        end
      end else begin
        hit = 1'b0;
      end
    end else if (blk == pcn_pkg::BLK_OMAP0 || blk == pcn_pkg::BLK_OMAP1) begin
      ow = {29'h0, blk[0], wi};
      for (int j = 0; j < pcn_pkg::FLD_PER_W; j++) begin
        rd[j * pcn_pkg::FLD_STEP +: pcn_pkg::MAP_W] =
          r_reg.outmap[ow * pcn_pkg::FLD_PER_W + j];
      end
    end else begin
      hit = 1'b0;
    end

    if (setup) begin
      r_next.pready = 1'b1;
      r_next.pslverr = ~hit;
      r_next.prdata = apb_req.pwrite ? '0 : rd;
    end else begin
      r_next.pready = 1'b0;
      r_next.pslverr = 1'b0;
    end

    // Writes take effect at the access edge only
    if (acc && apb_req.pwrite && hit) begin
      unique case (blk)
        pcn_pkg::BLK_ANS: begin
          // only bit 0 of port F is stored
          // only bits 9 to 6 of port G are stored
          if (wi == pcn_pkg::W_PORT_F_ANALOG_SELECT) begin
            r_next.port_f_analog_select = apb_req.pwdata[pcn_pkg::PORT_F_ANALOG_SELECT_BIT];
          end else begin
            r_next.port_g_analog_select = apb_req.pwdata[pcn_pkg::PORT_G_ANALOG_SELECT_LO +: pcn_pkg::PORT_G_ANALOG_SELECT_W];
          end
        end
        pcn_pkg::BLK_CNEN: begin
          r_next.cnen[wi * pcn_pkg::WD +: pcn_pkg::WD] = apb_req.pwdata;
        end
        pcn_pkg::BLK_CNPU: begin
          r_next.cnpu[wi * pcn_pkg::WD +: pcn_pkg::WD] = apb_req.pwdata;
        end
        pcn_pkg::BLK_CNPD: begin
          r_next.cnpd[wi * pcn_pkg::WD +: pcn_pkg::WD] = apb_req.pwdata;
        end
        pcn_pkg::BLK_FLAG: begin
          clr[wi * pcn_pkg::WD +: pcn_pkg::WD] = apb_req.pwdata;
        end
        pcn_pkg::BLK_CTL: begin
          // lock changes only with the key byte
          if (wi == pcn_pkg::W_LOCK) begin
            if (apb_req.pwdata[pcn_pkg::KEY_LO +: 8] == pcn_pkg::LOCK_KEY) begin
              r_next.lock = apb_req.pwdata[pcn_pkg::LOCK_BIT];
            end
          end else if (!r_reg.lock) begin
            // six-bit pin field per peripheral input
            for (int j = 0; j < pcn_pkg::PIN_IN_N; j++) begin
              r_next.inmap[j] = apb_req.pwdata[j * pcn_pkg::FLD_STEP +: pcn_pkg::MAP_W];
            end
          end
        end
        default: begin
          if (!r_reg.lock) begin
            for (int j = 0; j < pcn_pkg::FLD_PER_W; j++) begin
              r_next.outmap[ow * pcn_pkg::FLD_PER_W + j] =
                apb_req.pwdata[j * pcn_pkg::FLD_STEP +: pcn_pkg::MAP_W];
            end
          end
        end
      endcase
    end
    // only the 84 implemented inputs keep bits
    r_next.cnen = r_next.cnen & cn_mask;
    r_next.cnpu = r_next.cnpu & cn_mask;
    r_next.cnpd = r_next.cnpd & cn_mask;

    // sticky flags; a new change wins over a clear
    r_next.flag = (r_reg.flag & ~clr[pcn_pkg::CN_N-1:0]) | chg;
    // one request line for all enabled flags
    r_next.irq = |(r_next.flag & r_next.cnen[pcn_pkg::CN_N-1:0]);

    // analog mode blocks the digital read path
    r_next.f_rd = r_reg.filt[pcn_pkg::F_B] & ~r_reg.port_f_analog_select;
    r_next.g_rd = r_reg.filt[pcn_pkg::G_B +: pcn_pkg::PORT_G_ANALOG_SELECT_W] & ~r_reg.port_g_analog_select;

    // output routing exists for pins 0 to 31 only
    // pins 32 to 43 have no output field, so they never drive
    // only the listed peripheral outputs are selectable
    for (int k = 0; k < pcn_pkg::RP_IO; k++) begin
      code = r_reg.outmap[k];
      pv = (code != pcn_pkg::MAP_NULL && code <= pcn_pkg::FN_N) ? periph_out[code] : 1'b0;
      // remapped output over parallel port and port latch
      // a zero field falls through to the fixed functions
      if (usb_en[k]) begin
        r_next.rp_out[k] = usb_out[k];
      end else if (code != pcn_pkg::MAP_NULL) begin
        r_next.rp_out[k] = pv;
      end else if (pmp_en[k]) begin
        r_next.rp_out[k] = pmp_out[k];
      end else begin
        r_next.rp_out[k] = gpio_out[k];
      end
      // buffer follows direction or the fixed USB function, never an input map
      r_next.rp_oe_n[k] = ~usb_en[k] & tris[k];
    end

    // analog pins are cut off from remapped inputs
    // only pins below 44 can be selected
    for (int m = 0; m < pcn_pkg::PIN_IN_N; m++) begin
      sel = r_reg.inmap[m];
      if (sel < pcn_pkg::RP_N) begin
        r_next.pin_in[m] = ~rp_analog[sel] & r_reg.filt[pcn_pkg::RP_B + sel];
      end else begin
        r_next.pin_in[m] = 1'b0;
      end
    end
  end

  // Clock enable low freezes everything, including the input stages
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      r_reg <= '0;
      // port F select resets to analog
      r_reg.port_f_analog_select <= pcn_pkg::PORT_F_ANALOG_SELECT_RST;
      // port G selects reset to analog
      r_reg.port_g_analog_select <= pcn_pkg::PORT_G_ANALOG_SELECT_RST;
      // no pin for any input until software maps one
      r_reg.inmap <= {pcn_pkg::PIN_IN_N{pcn_pkg::NONE_PIN}};
      r_reg.rp_oe_n <= '1;
    end else if (clk_en) begin
      r_reg <= r_next;
    end
  end

  assign apb_rsp = '{prdata: r_reg.prdata, pready: r_reg.pready, pslverr: r_reg.pslverr};
  assign periph_in = r_reg.pin_in;
  assign rp_out = r_reg.rp_out;
  assign rp_oe_n = r_reg.rp_oe_n;
  assign cn_irq = r_reg.irq;
  assign pullup_en = r_reg.cnpu[pcn_pkg::CN_N-1:0];
  assign pulldown_en = r_reg.cnpd[pcn_pkg::CN_N-1:0];
  assign portf_pin0_analog_sel = r_reg.port_f_analog_select;
  assign portg_pins_analog_sel = r_reg.port_g_analog_select;
  assign portf_read = r_reg.f_rd;
  assign portg_read = r_reg.g_rd;

  a_port_f_analog_select_zero_hi: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    clk_en && setup && !apb_req.pwrite && apb_req.paddr == pcn_pkg::PORT_F_ANALOG_SELECT_OFF
    |=> apb_rsp.pready && apb_rsp.prdata[31:1] == '0)
    else $error("Unimplemented port F select bits read nonzero");

  a_analog_blocks_read: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    clk_en && r_reg.port_f_analog_select |=> !portf_read)
    else $error("Port F read active in analog mode");

  a_change_sets_flag: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    clk_en && (chg != '0) |=> (r_reg.flag & $past(chg)) == $past(chg))
    else $error("Enabled change did not set its flag");

  a_irq_has_cause: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    cn_irq |-> |(r_reg.flag & r_reg.cnen[pcn_pkg::CN_N-1:0]))
    else $error("Change interrupt without an enabled flag");

  a_usb_over_map: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    clk_en && usb_en[0] |=> rp_out[0] == $past(usb_out[0]) && !rp_oe_n[0])
    else $error("USB output lost pin 0");

  a_null_map_pmp: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    clk_en && !usb_en[0] && r_reg.outmap[0] == pcn_pkg::MAP_NULL && pmp_en[0]
    |=> rp_out[0] == $past(pmp_out[0]))
    else $error("Null map did not pass parallel port output");

  a_lock_holds_map: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    r_reg.lock ##1 r_reg.lock |-> $stable(r_reg.outmap) && $stable(r_reg.inmap))
    else $error("Mapping changed while locked");

  a_analog_cuts_input: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    clk_en && r_reg.inmap[0] < pcn_pkg::RP_N && rp_analog[r_reg.inmap[0]]
    |=> !periph_in[0])
    else $error("Remapped input fed from analog pin");

  a_port_g_analog_select_zero_bits: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    clk_en && setup && !apb_req.pwrite && blk == pcn_pkg::BLK_ANS && wi == pcn_pkg::W_PORT_G_ANALOG_SELECT
    |=> apb_rsp.prdata[pcn_pkg::PORT_G_ANALOG_SELECT_LO-1:0] == '0 &&
        apb_rsp.prdata[pcn_pkg::WD-1:pcn_pkg::PORT_G_ANALOG_SELECT_LO+pcn_pkg::PORT_G_ANALOG_SELECT_W] == '0)
    else $error("Unimplemented port G select bits read nonzero");

  a_gport_blocks_read: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    clk_en |=> (portg_read & $past(r_reg.port_g_analog_select)) == '0)
    else $error("Port G read active in analog mode");

  a_irq_follows_flag: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    clk_en && !acc && |(r_reg.flag & r_reg.cnen[pcn_pkg::CN_N-1:0]) |=> cn_irq)
    else $error("Enabled flag did not raise the change interrupt");

  a_disabled_no_flag: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    clk_en && !acc && !r_reg.cnen[6] |=> $stable(r_reg.flag[6]))
    else $error("Disabled change input set its flag");

  a_oe_from_dir: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    clk_en |=> rp_oe_n == (~$past(usb_en) & $past(tris)))
    else $error("Pin output enable not set by direction or USB");

  a_unmapped_input: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    clk_en && r_reg.inmap[1] >= pcn_pkg::RP_N |=> !periph_in[1])
    else $error("Unmapped peripheral input saw a pin");

  a_lock_needs_key: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    clk_en && acc && apb_req.pwrite && blk == pcn_pkg::BLK_CTL && wi == pcn_pkg::W_LOCK &&
    apb_req.pwdata[pcn_pkg::KEY_LO +: 8] != pcn_pkg::LOCK_KEY |=> $stable(r_reg.lock))
    else $error("Lock changed without its key");

  a_reset_analog: assert property (
    @(posedge ref_clk)
    !reset_n |=> portf_pin0_analog_sel == pcn_pkg::PORT_F_ANALOG_SELECT_RST &&
      portg_pins_analog_sel == pcn_pkg::PORT_G_ANALOG_SELECT_RST)
    else $error("Analog selects not set by reset");
endmodule

`default_nettype wire

// ### tb/pcn_pins_model.sv
// Pin, pad and peripheral side model driving the pin function block
`timescale 1ns/1ps
`default_nettype none
module pcn_pins_model (
  output var logic [83:0] cn_pin,
  output var logic [43:0] rp_pin,
  output var logic portf_pad,
  output var logic [3:0] portg_pad,
  output var logic [43:0] rp_analog,
  output var logic [31:0] tris,
  output var logic [31:0] gpio_out,
  output var logic [31:0] pmp_en,
  output var logic [31:0] pmp_out,
  output var logic [31:0] usb_en,
  output var logic [31:0] usb_out,
  output var logic [25:1] periph_out
);
  // Pin 0 driven as output, so its pull-up stays off
  // Top two change inputs only move once the transceiver is off
  logic usb_transceiver_disable;
  initial begin
    usb_transceiver_disable = 1'b1;
    cn_pin = '0;
    rp_pin = '0;
    portf_pad = 1'b1;
    portg_pad = 4'hf;
    rp_analog = '0;
    tris = 32'hfffffffe;
    gpio_out = '0;
    pmp_en = '0;
    pmp_out = '0;
    usb_en = '0;
    usb_out = '0;
    periph_out = 25'h4;
  end
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench for the pin function block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic clk_en = 1'b1;
  pcn_pkg::pcn_apb_req_s req = '0;
  pcn_pkg::pcn_apb_rsp_s rsp;
  wire logic [83:0] cn_pin;
  wire logic [43:0] rp_pin, rp_analog;
  wire logic portf_pad;
  wire logic [3:0] portg_pad;
  wire logic [31:0] tris, gpio_out, pmp_en, pmp_out, usb_en, usb_out;
  wire logic [25:1] periph_out;
  logic [3:0] periph_in, portg_pins_analog_sel, portg_read;
  logic [31:0] rp_out, rp_oe_n, rdat;
  logic [83:0] pullup_en, pulldown_en;
  logic cn_irq, portf_pin0_analog_sel, portf_read, rerr;
  int error_cnt = 0;
  int samples_checked = 0;
  int cyc = 0;
  int n;

  pcn_pins_model PIN (.cn_pin(cn_pin), .rp_pin(rp_pin), .portf_pad(portf_pad),
    .portg_pad(portg_pad), .rp_analog(rp_analog), .tris(tris), .gpio_out(gpio_out),
    .pmp_en(pmp_en), .pmp_out(pmp_out), .usb_en(usb_en), .usb_out(usb_out),
    .periph_out(periph_out));

  pcn_pin_func DUT (.ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en),
    .apb_req(req), .apb_rsp(rsp), .cn_pin(cn_pin), .rp_pin(rp_pin),
    .portf_pad(portf_pad), .portg_pad(portg_pad), .rp_analog(rp_analog), .tris(tris),
    .gpio_out(gpio_out), .pmp_en(pmp_en), .pmp_out(pmp_out), .usb_en(usb_en),
    .usb_out(usb_out), .periph_out(periph_out), .periph_in(periph_in), .rp_out(rp_out),
    .rp_oe_n(rp_oe_n), .cn_irq(cn_irq), .pullup_en(pullup_en), .pulldown_en(pulldown_en),
    .portf_pin0_analog_sel(portf_pin0_analog_sel),
    .portg_pins_analog_sel(portg_pins_analog_sel), .portf_read(portf_read),
    .portg_read(portg_read));

  always #20 ref_clk = ~ref_clk;

  // Hang guard, well above the roughly 140 cycles the run needs
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      results();
    end
  end

  task automatic results();
    if (error_cnt == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string s, input logic [95:0] e, input logic [95:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask

  // One APB transfer; an idle edge after it keeps back-to-back calls apart
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge ref_clk);
    req.penable <= 1'b1;
    @(posedge ref_clk);
    while (rsp.pready !== 1'b1) @(posedge ref_clk);
    rdat = rsp.prdata;
    rerr = rsp.pslverr;
    req <= '0;
    @(posedge ref_clk);
  endtask

  task automatic rdchk(input string s, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, '0);
    chk(s, e, rdat);
  endtask

  task automatic edges(input int k);
    repeat (k) @(posedge ref_clk);
  endtask

  task automatic t_analog();
    rdchk("port_f_analog_select reset", 8'h00, 32'h1);
    rdchk("port_g_analog_select reset", 8'h04, 32'h3c0);
    chk("port_f_analog_select out", 1'b1, portf_pin0_analog_sel);
    chk("port_g_analog_select out", 4'hf, portg_pins_analog_sel);
    chk("portf read analog", 1'b0, portf_read);
    apb(1'b1, 8'h00, 32'hffffffff);
    rdchk("port_f_analog_select ones", 8'h00, 32'h1);
    apb(1'b1, 8'h04, 32'hffffffff);
    rdchk("port_g_analog_select ones", 8'h04, 32'h3c0);
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b1, 8'h04, 32'h0);
    rdchk("port_g_analog_select zero", 8'h04, 32'h0);
    for (n = 0; n < 20 && portf_read !== 1'b1; n++) @(posedge ref_clk);
    chk("portf read digital", 1'b1, portf_read);
    chk("portg read digital", 4'hf, portg_read);
  endtask

  task automatic t_change();
    apb(1'b1, 8'h10, 32'h20);
    PIN.cn_pin[6] <= 1'b1;
    edges(15);
    chk("irq masked pin", 1'b0, cn_irq);
    PIN.cn_pin[5] <= 1'b1;
    for (n = 0; n < 20 && cn_irq !== 1'b1; n++) @(posedge ref_clk);
    chk("irq on change", 1'b1, cn_irq);
    rdchk("flag word", 8'h40, 32'h20);
    apb(1'b1, 8'h40, 32'h20);
    for (n = 0; n < 10 && cn_irq !== 1'b0; n++) @(posedge ref_clk);
    chk("irq cleared", 1'b0, cn_irq);
    apb(1'b1, 8'h18, 32'h80000);
    clk_en <= 1'b0;
    chk("transceiver off", 1'b1, PIN.usb_transceiver_disable);
    PIN.cn_pin[83] <= 1'b1;
    edges(8);
    clk_en <= 1'b1;
    for (n = 0; n < 20 && cn_irq !== 1'b1; n++) @(posedge ref_clk);
    chk("irq after sleep", 1'b1, cn_irq);
    rdchk("flag pin 83", 8'h48, 32'h80000);
  endtask

  task automatic t_pulls();
    apb(1'b1, 8'h20, 32'h2);
    apb(1'b1, 8'h38, 32'h80000);
    edges(2);
    chk("pullup", 84'h2, pullup_en);
    chk("pulldown", {1'b1, 83'h0}, pulldown_en);
  endtask

  task automatic t_pins();
    chk("no default pin", 1'b0, rp_out[0]);
    chk("oe from tris", 2'b10, rp_oe_n[1:0]);
    apb(1'b1, 8'h54, 32'h3f3f3f28);
    PIN.rp_pin[40] <= 1'b1;
    for (n = 0; n < 20 && periph_in[0] !== 1'b1; n++) @(posedge ref_clk);
    chk("input only pin", 1'b1, periph_in[0]);
    PIN.rp_analog[40] <= 1'b1;
    for (n = 0; n < 20 && periph_in[0] !== 1'b0; n++) @(posedge ref_clk);
    chk("analog cuts input", 1'b0, periph_in[0]);
    chk("input no buffer", 2'b10, rp_oe_n[1:0]);
    PIN.pmp_en[0] <= 1'b1;
    apb(1'b1, 8'h60, 32'h3);
    edges(2);
    chk("map over pmp", 1'b1, rp_out[0]);
    PIN.usb_en[0] <= 1'b1;
    edges(3);
    chk("usb over map", 1'b0, rp_out[0]);
    apb(1'b1, 8'h50, 32'h1);
    apb(1'b1, 8'h60, 32'h5);
    rdchk("no key no lock", 8'h60, 32'h5);
    apb(1'b1, 8'h50, 32'ha501);
    apb(1'b1, 8'h60, 32'h0);
    rdchk("locked map", 8'h60, 32'h5);
    apb(1'b0, 8'hfc, '0);
    chk("unmapped", 1'b1, rerr);
  endtask

  initial begin
    edges(12);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    t_analog();
    t_change();
    t_pulls();
    t_pins();
    results();
  end
endmodule
`default_nettype wire
